// ==== verilog/trxs_pkg.sv ====
/*
  constants, types and register map for the table-read / xor / skip
  execution unit; assumes a byte-addressed axi4-lite master and
  synchronous program and data memories with one cycle of read latency.
*/
package trxs_pkg;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_MADDR  = 8'h04;
  localparam logic [7:0] OFF_ACC    = 8'h08;
  localparam logic [7:0] OFF_TAB_LOW  = 8'h0c;
  localparam logic [7:0] OFF_TAB_PAGE = 8'h10;
  localparam logic [7:0] OFF_TAB_HIGH = 8'h14;
  localparam logic [7:0] OFF_STATUS   = 8'h18;
  // low address bits of an aligned word
  localparam logic [1:0] WORD_ALIGNED = 2'h0;

  // field positions
  localparam int unsigned CTRL_OP_LSB  = 0;
  localparam int unsigned CTRL_BIT_LSB = 4;
  localparam int unsigned CTRL_START   = 8;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_Z       = 1;
  localparam int unsigned STAT_SKIP    = 2;
  localparam int unsigned STAT_CYC_LSB = 4;

  // the fixed last page of program memory
  localparam logic [7:0] LAST_PAGE = 8'hff;

  // reset values
  localparam logic [7:0]  BYTE_RST = 8'h00;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [31:0] BUS_RST  = 32'h0000_0000;

  // instruction cycle counts reported in status
  localparam logic [1:0] CYC_NONE = 2'h0;
  localparam logic [1:0] CYC_ONE  = 2'h1;
  localparam logic [1:0] CYC_TWO  = 2'h2;
  localparam logic [1:0] CYC_SKIP = 2'h3;

  // instructions of this group
  typedef enum logic [2:0] {
    OP_SKIP_ON_CLEAR_BIT   = 3'h0,
    OP_TABLE_READ_PAGED    = 3'h1,
    OP_TABLE_READ_FINAL    = 3'h2,
    OP_PREINC_READ_PAGED   = 3'h3,
    OP_PREINC_READ_FINAL   = 3'h4,
    OP_XOR_INTO_ACCUM      = 3'h5,
    OP_XOR_INTO_MEMORY     = 3'h6,
    OP_ILLEGAL             = 3'h7
  } trxs_op_t;

  // execution states
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_OPERAND = 3'h1,
    ST_EXEC    = 3'h2,
    ST_PWAIT   = 3'h3,
    ST_PDATA   = 3'h4
  } trxs_state_t;

endpackage : trxs_pkg

// ==== verilog/trxs_exec.sv ====
/*
  execution unit for the skip, table-read and xor instructions, with
  its accumulator, zero flag, table pointers and table-high latch,
  reached over an axi4-lite slave.
  assumes both memories return read data one clock after the address
  and run on aclk; writes strobe for one cycle.
*/
`timescale 1ns/1ps
module trxs_exec
  import trxs_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // data memory
  output logic [7:0]       dmem_addr,
  input  wire logic [7:0]  dmem_rdata,
  output logic [7:0]       dmem_wdata,
  output logic             dmem_we,
  // program memory
  output logic [15:0]      pmem_addr,
  input  wire logic [15:0] pmem_rdata,
  // core side status
  output logic             skip_next,
  output logic             zero_flag,
  output logic             busy
);

  // bus slave state
  logic        aw_held_ff, nxt_aw_held;
  logic        w_held_ff,  nxt_w_held;
  logic [7:0]  awaddr_ff,  nxt_awaddr;
  logic [31:0] wdata_ff,   nxt_wdata;
  logic [3:0]  wstrb_ff,   nxt_wstrb;
  logic        bvalid_ff,  nxt_bvalid;
  logic [1:0]  bresp_ff,   nxt_bresp;
  logic        rvalid_ff,  nxt_rvalid;
  logic [31:0] rdata_ff,   nxt_rdata;
  logic [1:0]  rresp_ff,   nxt_rresp;

  // core state
  trxs_state_t state_ff,   nxt_state;
  trxs_op_t    op_ff,      nxt_op;
  logic [2:0]  bitsel_ff,  nxt_bitsel;
  logic [7:0]  maddr_ff,   nxt_maddr;
  logic [7:0]  acc_ff,     nxt_acc;
  logic [7:0]  table_low_pointer_ff,  nxt_table_low_pointer;
  logic [7:0]  table_page_pointer_ff, nxt_table_page_pointer;
  logic [7:0]  table_high_latch_ff,   nxt_table_high_latch;
  logic        z_ff,       nxt_z;
  logic        skipped_ff, nxt_skipped;
  logic [1:0]  cycles_ff,  nxt_cycles;
  logic        skip_ff,    nxt_skip;
  logic [7:0]  daddr_ff,   nxt_daddr;
  logic [7:0]  dwdata_ff,  nxt_dwdata;
  logic        dwe_ff,     nxt_dwe;
  logic [15:0] paddr_ff,   nxt_paddr;

  // shared between the two groups
  logic        bus_wr;
  logic [31:0] ctrl_word;
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic        wr_hit;
  logic [31:0] ctrl_merged;
  trxs_op_t    wr_op;
  logic [7:0]  xor_res;
  logic [7:0]  ptr_low;
  logic [7:0]  ptr_page;

  // a write lands once both halves are held and no response is pending
  assign bus_wr        = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  // readable views of control and status
  assign ctrl_word   = {23'h000000, 1'b0, 1'b0, bitsel_ff, 1'b0, op_ff};
  assign status_word = {26'h0000000, cycles_ff, 1'b0, skipped_ff, z_ff, busy};
  assign ctrl_merged = {ctrl_word[31:16],
                        (wstrb_ff[1] ? wdata_ff[15:8] : ctrl_word[15:8]),
                        (wstrb_ff[0] ? wdata_ff[7:0] : ctrl_word[7:0])};
  assign wr_op       = trxs_op_t'(ctrl_merged[CTRL_OP_LSB +: 3]);

  // mapped words are the aligned ones from control up to status
  assign rd_hit = (s_axi_araddr <= OFF_STATUS) &&
                  (s_axi_araddr[1:0] == WORD_ALIGNED);
  // read-only words answer okay and drop the write
  assign wr_hit = (awaddr_ff <= OFF_STATUS) &&
                  (awaddr_ff[1:0] == WORD_ALIGNED);

  // register read decode
  always_comb begin
    unique case (s_axi_araddr)
      OFF_CTRL:     rd_mux = ctrl_word;
      OFF_MADDR:    rd_mux = {24'h000000, maddr_ff};
      OFF_ACC:      rd_mux = {24'h000000, acc_ff};
      OFF_TAB_LOW:  rd_mux = {24'h000000, table_low_pointer_ff};
      OFF_TAB_PAGE: rd_mux = {24'h000000, table_page_pointer_ff};
      OFF_TAB_HIGH: rd_mux = {24'h000000, table_high_latch_ff};
      OFF_STATUS:   rd_mux = status_word;
      default:      rd_mux = BUS_RST;
    endcase
  end

  // axi slave channels, address and data taken in either order
  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wdata   = wdata_ff;
    nxt_wstrb   = wstrb_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_rvalid  = rvalid_ff;
    nxt_rdata   = rdata_ff;
    nxt_rresp   = rresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_wdata  = s_axi_wdata;
      nxt_wstrb  = s_axi_wstrb;
    end
    if (bus_wr) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = rd_mux;
      nxt_rresp  = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= BYTE_RST;
      wdata_ff   <= BUS_RST;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= BUS_RST;
      rresp_ff   <= RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awaddr_ff  <= nxt_awaddr;
      wdata_ff   <= nxt_wdata;
      wstrb_ff   <= nxt_wstrb;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      rvalid_ff  <= nxt_rvalid;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end
  end

  // operand datapath
  assign xor_res  = acc_ff ^ dmem_rdata;
  // pre-increment wraps in eight bits, page never carried into
  assign ptr_low  = (wr_op == OP_PREINC_READ_PAGED ||
                     wr_op == OP_PREINC_READ_FINAL) ?
                    table_low_pointer_ff + 8'h01 : table_low_pointer_ff;
  assign ptr_page = (wr_op == OP_TABLE_READ_FINAL ||
                     wr_op == OP_PREINC_READ_FINAL) ?
                    LAST_PAGE : table_page_pointer_ff;

  // register writes, start, and the execution sequence
  always_comb begin
    nxt_state   = state_ff;
    nxt_op      = op_ff;
    nxt_bitsel  = bitsel_ff;
    nxt_maddr   = maddr_ff;
    nxt_acc     = acc_ff;
    nxt_table_low_pointer  = table_low_pointer_ff;
    nxt_table_page_pointer = table_page_pointer_ff;
    nxt_table_high_latch   = table_high_latch_ff;
    nxt_z       = z_ff;
    nxt_skipped = skipped_ff;
    nxt_cycles  = cycles_ff;
    nxt_skip    = 1'b0;
    nxt_daddr   = daddr_ff;
    nxt_dwdata  = dwdata_ff;
    nxt_dwe     = 1'b0;
    nxt_paddr   = paddr_ff;
    unique case (state_ff)
      ST_IDLE: begin
        // writes while busy are dropped so state cannot tear mid-op
        // byte registers sit in lane 0 only
        if (bus_wr && wstrb_ff[0]) begin
          unique case (awaddr_ff)
            OFF_MADDR:    nxt_maddr              = wdata_ff[7:0];
            OFF_ACC:      nxt_acc                = wdata_ff[7:0];
            OFF_TAB_LOW:  nxt_table_low_pointer  = wdata_ff[7:0];
            OFF_TAB_PAGE: nxt_table_page_pointer = wdata_ff[7:0];
            default: ;
          endcase
        end
        if (bus_wr && awaddr_ff == OFF_CTRL) begin
          nxt_op     = wr_op;
          nxt_bitsel = ctrl_merged[CTRL_BIT_LSB +: 3];
        end
        if (bus_wr && awaddr_ff == OFF_CTRL && ctrl_merged[CTRL_START] &&
            wr_op != OP_ILLEGAL) begin
          nxt_skipped = 1'b0;
          nxt_cycles  = CYC_NONE;
          nxt_daddr   = maddr_ff;
          unique case (wr_op)
            OP_TABLE_READ_PAGED, OP_TABLE_READ_FINAL,
            OP_PREINC_READ_PAGED, OP_PREINC_READ_FINAL: begin
              nxt_table_low_pointer = ptr_low;
              nxt_paddr = {ptr_page, ptr_low};
              nxt_state = ST_PWAIT;
            end
            default: nxt_state = ST_OPERAND;
          endcase
        end
      end
      ST_OPERAND: nxt_state = ST_EXEC;
      ST_EXEC: begin
        nxt_state = ST_IDLE;
        nxt_cycles = CYC_ONE;
        unique case (op_ff)
          OP_SKIP_ON_CLEAR_BIT: begin
            // set bit: fall through, nothing written, flags kept
            if (!dmem_rdata[bitsel_ff]) begin
              nxt_skip    = 1'b1;
              nxt_skipped = 1'b1;
              nxt_cycles  = CYC_SKIP;
            end
          end
          OP_XOR_INTO_ACCUM: begin
            nxt_acc = xor_res;
            nxt_z   = (xor_res == BYTE_RST);
          end
          OP_XOR_INTO_MEMORY: begin
            nxt_dwdata = xor_res;
            nxt_dwe    = 1'b1;
            nxt_z      = (xor_res == BYTE_RST);
          end
          default: ;
        endcase
      end
      ST_PWAIT: nxt_state = ST_PDATA;
      ST_PDATA: begin
        // table reads leave the zero flag alone
        nxt_dwdata = pmem_rdata[7:0];
        nxt_table_high_latch = pmem_rdata[15:8];
        nxt_dwe    = 1'b1;
        nxt_cycles = CYC_TWO;
        nxt_state  = ST_IDLE;
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff   <= ST_IDLE;
      op_ff      <= OP_SKIP_ON_CLEAR_BIT;
      bitsel_ff  <= 3'h0;
      maddr_ff   <= BYTE_RST;
      acc_ff     <= BYTE_RST;
      table_low_pointer_ff  <= BYTE_RST;
      table_page_pointer_ff <= BYTE_RST;
      table_high_latch_ff   <= BYTE_RST;
      z_ff       <= 1'b0;
      skipped_ff <= 1'b0;
      cycles_ff  <= CYC_NONE;
      skip_ff    <= 1'b0;
      daddr_ff   <= BYTE_RST;
      dwdata_ff  <= BYTE_RST;
      dwe_ff     <= 1'b0;
      paddr_ff   <= WORD_RST;
    end else begin
      state_ff   <= nxt_state;
      op_ff      <= nxt_op;
      bitsel_ff  <= nxt_bitsel;
      maddr_ff   <= nxt_maddr;
      acc_ff     <= nxt_acc;
      table_low_pointer_ff  <= nxt_table_low_pointer;
      table_page_pointer_ff <= nxt_table_page_pointer;
      table_high_latch_ff   <= nxt_table_high_latch;
      z_ff       <= nxt_z;
      skipped_ff <= nxt_skipped;
      cycles_ff  <= nxt_cycles;
      skip_ff    <= nxt_skip;
      daddr_ff   <= nxt_daddr;
      dwdata_ff  <= nxt_dwdata;
      dwe_ff     <= nxt_dwe;
      paddr_ff   <= nxt_paddr;
    end
  end

  // memory and status outputs from flops, busy decoded from the state
  assign dmem_addr  = daddr_ff;
  assign dmem_wdata = dwdata_ff;
  assign dmem_we    = dwe_ff;
  assign pmem_addr  = paddr_ff;
  assign skip_next  = skip_ff;
  assign zero_flag  = z_ff;
  assign busy       = (state_ff != ST_IDLE);

endmodule : trxs_exec

// ==== sim/trxs_mem_model.sv ====
/*
  memories on the far side of trxs_exec: 256 bytes of data memory
  and a 64k-word program memory.
  assumes aclk is the execution clock; reads answer one clock later.
*/
`timescale 1ns/1ps
module trxs_mem_model (
  // clock
  input  wire logic        aclk,
  // data memory
  input  wire logic [7:0]  dmem_addr,
  output logic      [7:0]  dmem_rdata,
  input  wire logic [7:0]  dmem_wdata,
  input  wire logic        dmem_we,
  // program memory
  input  wire logic [15:0] pmem_addr,
  output logic      [15:0] pmem_rdata
);
  logic [7:0]  dm [0:255];
  logic [15:0] pm [0:65535];

  // plain always: the bench preloads both arrays while the unit idles
  always @(posedge aclk) begin
    dmem_rdata <= dm[dmem_addr];
    pmem_rdata <= pm[pmem_addr];
    if (dmem_we) dm[dmem_addr] <= dmem_wdata;
  end
endmodule : trxs_mem_model

// ==== sim/trxs_exec_sva.sv ====
/*
  timing checks on the execution outputs of trxs_exec.
  assumes a single aclk domain with synchronous active-low aresetn.
*/
`timescale 1ns/1ps
module trxs_exec_sva
  import trxs_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // execution outputs
  input wire logic        busy,
  input wire logic        skip_next,
  input wire logic        zero_flag,
  input wire logic        dmem_we,
  input wire logic [7:0]  dmem_addr,
  input wire logic [15:0] pmem_addr
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // two busy cycles, then idle
  sequence s_run;
    busy [*2] ##1 !busy;
  endsequence
  // first idle cycle after a run
  sequence s_end;
    !busy && $past(busy);
  endsequence

  AST_RUN_LEN: assert property ($rose(busy) |-> s_run)
    else $error("run length wrong");
  AST_SKIP_END: assert property (skip_next |-> s_end)
    else $error("skip pulse out of place");
  AST_SKIP_PULSE: assert property (skip_next |=> !skip_next)
    else $error("skip pulse too long");
  AST_SKIP_KEEP: assert property (skip_next |-> !dmem_we && $stable(zero_flag))
    else $error("skip touched operand or flag");
  AST_PADDR_HOLD: assert property (busy && $past(busy) |-> $stable(pmem_addr))
    else $error("table address moved");
  AST_WE_END: assert property (dmem_we |-> s_end ##1 !dmem_we)
    else $error("write strobe out of place");
  AST_Z_END: assert property ($changed(zero_flag) |-> s_end)
    else $error("zero flag changed mid run");
  AST_MADDR_HOLD: assert property (dmem_we || (busy && $past(busy))
    |-> $stable(dmem_addr))
    else $error("operand address moved");
endmodule : trxs_exec_sva

bind trxs_exec trxs_exec_sva i_sva (.aclk, .aresetn, .busy, .skip_next,
  .zero_flag, .dmem_we, .dmem_addr, .pmem_addr);

// ==== sim/testbench.sv ====
/*
  self-checking bench for trxs_exec: instruction loop over op = i % 8 with random operands against
  an integer model. assumes trxs_mem_model as the memories.
*/
`timescale 1ns/1ps
module testbench;
  import trxs_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, dmem_we;
  logic        skip_next, zero_flag, busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dmem_addr, dmem_rdata, dmem_wdata;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [15:0] pmem_addr, pmem_rdata;
  int          err_count, checks_done, cyc, seed, n_skip, n_we;
  int          ez, eth, esk, ecy;

  trxs_exec i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .dmem_addr, .dmem_rdata, .dmem_wdata, .dmem_we,
    .pmem_addr, .pmem_rdata, .skip_next, .zero_flag, .busy);
  trxs_mem_model i_mem (.aclk, .dmem_addr, .dmem_rdata, .dmem_wdata,
    .dmem_we, .pmem_addr, .pmem_rdata);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // pulse counters and the hang ceiling
  always @(posedge aclk) begin
    cyc++;
    if (skip_next === 1'b1) n_skip++;
    if (dmem_we === 1'b1) n_we++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // ready is judged at the negedge, so it equals what the edge samples
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic       ha, hw, hb;
    logic [1:0] rs;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    chk(32'(rs), 32'(RESP_OKAY));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    logic        ha, hr;
    logic [31:0] d;
    logic [1:0]  rs;
    hr = 1'b0;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    chk(d, e);
    chk(32'(rs), 32'(er));
  endtask : axr

  task automatic run_op(input int i);
    int op, a, b, ac, lp, hp, m, em, w, nl, pg, sk, we, s0, w0;
    op = i % 8;
    a = $random(seed) & 255;
    b = $random(seed) & 7;
    ac = $random(seed) & 255;
    lp = (i % 3 == 0) ? 255 : $random(seed) & 255;
    hp = $random(seed) & 255;
    m = $random(seed) & 255;
    w = $random(seed) & 16'hffff;
    if (op == 0) m = ((i / 8) % 2) ? m | (1 << b) : m & ~(1 << b);
    if (op > 4 && (i / 8) % 3 == 0) ac = m;
    nl = (op == 3 || op == 4) ? (lp + 1) & 255 : lp;
    pg = (op == 2 || op == 4) ? 255 : hp;
    i_mem.dm[a] = 8'(m);
    i_mem.pm[pg * 256 + nl] = 16'(w);
    axw(OFF_MADDR, 32'(a));
    axw(OFF_ACC, 32'(ac));
    axw(OFF_TAB_LOW, 32'(lp));
    axw(OFF_TAB_PAGE, 32'(hp));
    axw(OFF_TAB_HIGH, 32'($random(seed)));
    s0 = n_skip;
    w0 = n_we;
    axw(OFF_CTRL, 32'(op) | 32'(b << 4) | 32'h100);
    @(negedge aclk);
    for (int t = 0; t < 20 && busy !== 1'b0; t++) @(negedge aclk);
    // model of the instruction just run
    em = m;
    sk = 0;
    we = 0;
    case (op)
      0: begin
        sk = ((m >> b) & 1) == 0;
        ecy = sk ? 3 : 1;
      end
      1, 2, 3, 4: begin
        lp = nl;
        em = w & 255;
        eth = w >> 8;
        we = 1;
        ecy = 2;
      end
      5: begin
        ac = ac ^ m;
        ez = (ac == 0);
        ecy = 1;
      end
      6: begin
        em = ac ^ m;
        ez = (em == 0);
        we = 1;
        ecy = 1;
      end
      default: ;
    endcase
    if (op < 7) esk = sk;
    axr(OFF_ACC, 32'(ac), RESP_OKAY);
    axr(OFF_TAB_LOW, 32'(lp), RESP_OKAY);
    axr(OFF_TAB_PAGE, 32'(hp), RESP_OKAY);
    axr(OFF_TAB_HIGH, 32'(eth), RESP_OKAY);
    axr(OFF_STATUS, 32'(ecy * 16 + esk * 4 + ez * 2), RESP_OKAY);
    chk(32'(zero_flag), 32'(ez));
    chk(32'(i_mem.dm[a]), 32'(em));
    chk(32'(n_skip - s0), 32'(sk));
    chk(32'(n_we - w0), 32'(we));
    $display("test %0d op %0d done", i, op);
  endtask : run_op

  // reset, then the status reset value, an unmapped read and the random loop
  initial begin
    seed = 74;
    aresetn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_awprot = 3'h0;
    s_axi_arprot = 3'h0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    axr(OFF_STATUS, 32'h0, RESP_OKAY);
    axr(8'h1c, 32'h0, RESP_SLVERR);
    for (int i = 0; i < 48; i++) run_op(i);
    conclude();
  end
endmodule : testbench
